// *** src/lock_pkg.sv ***
/*
  constants, encodings and the behaviour notes for the code memory lock
  block; assumes a 40 MHz core clock and a programmer on plain pins.
*/
// Notes on behaviour
// R1: no lock bits set means no protection; verify still scrambled if keyed.
// R2: lock one stops external table reads and programming, latches access pin.
// R3: locks one and two add verify disable to level one.
// R4: all three locks also block external execution and data RAM.
// R5: programmer uses only the four defined lock combinations.
// R6: programmer gives five low strobe pulses per item at raised supply.
// R7: strobe low 100us plus or minus 10us, high at least 10us.
// R8: programmer raises supply 10us before first strobe, holds 10us after.
// R9: device clock stays within 4 to 6 MHz during program and verify; the model runs core_clk at 40 MHz throughout.
// R10: 64-byte key array reads all ones until programmed.
// R11: code image holds 4 Kbyte code then 64-byte key.
// R12: mask parts: lock one disables external reads, latches access pin.
// R13: mask parts: lock two stops verify read-out.
// R14: code image sets lock two only with lock one.
// R15: keyed verify byte is xnor of code byte and selected key byte.
// R16: lock bits persist across reset, cleared only by whole-array erase.
package lock_pkg;
  // ****************************************************************
  // sizes and reset values
  // ****************************************************************
  localparam int KEY_DEPTH = 64;
  localparam int KEY_AW = 6;
  localparam int CODE_AW = 12;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [2:0] LOCKS_ERASED = 3'h0;
  localparam int PULSES_PER_ITEM = 5;
  // ****************************************************************
  // strobe timing at 40 MHz
  // ****************************************************************
  localparam int CLK_NS = 25;
  localparam int PULSE_MIN_US = 90;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 13;
  // ****************************************************************
  // programming modes
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b000,
    MODE_CODE = 3'b001,
    MODE_KEY = 3'b010,
    MODE_LOCK1 = 3'b011,
    MODE_LOCK2 = 3'b100,
    MODE_LOCK3 = 3'b101,
    MODE_VERIFY = 3'b110
  } program_strobe_mode_e;
  typedef enum logic [1:0] {
    ST_HIGH = 2'b00,
    ST_LOW = 2'b01,
    ST_DONE = 2'b10
  } strobe_state_e;
endpackage

// *** src/strobe_counter.sv ***
/*
  counts qualified low pulses of the program strobe; assumes the strobe
  is synchronous to core_clk and the supply flag is steady meanwhile.
*/
`timescale 1ns/1ps
module strobe_counter
  import lock_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic program_strobe_n,
  input wire logic supply_raised,
  input wire logic item_start,
  output logic item_done
);
  strobe_state_e state;
  logic [CNT_W-1:0] low_cnt;
  logic [2:0] pulses;

  // ****************************************************************
  // pulse qualification
  // ****************************************************************
  // short glitches are dropped: only a low of at least the minimum counts
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_HIGH;
      low_cnt <= '0;
      pulses <= 3'h0;
    end else if (item_start) begin
      state <= ST_HIGH;
      low_cnt <= '0;
      pulses <= 3'h0;
    end else begin
      case (state)
        ST_HIGH: begin
          low_cnt <= '0;
          if (!program_strobe_n && supply_raised) begin
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (program_strobe_n) begin
            if (low_cnt >= CNT_W'(PULSE_MIN_CYC)) begin
              pulses <= pulses + 3'h1; // [R6]
            end
            state <= (pulses == 3'(PULSES_PER_ITEM - 1) &&
                      low_cnt >= CNT_W'(PULSE_MIN_CYC)) ? ST_DONE : ST_HIGH;
          end else if (!(&low_cnt)) begin
            low_cnt <= low_cnt + 1'b1;
          end
        end
        default: state <= ST_DONE;
      endcase
    end
  end

  assign item_done = (state == ST_DONE);
endmodule // strobe_counter

// *** src/code_memory_security_lock.sv ***
/*
  lock bits, key array and verify scrambling for the on-chip code memory;
  assumes the lock and key storage is nonvolatile and only a full erase
  (erase_all) returns it to the erased state.
*/
`timescale 1ns/1ps
module code_memory_security_lock
  import lock_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic erase_all,
  input wire logic [2:0] program_strobe_mode,
  input wire logic supply_raised,
  input wire logic program_strobe_n,
  input wire logic [CODE_AW-1:0] program_strobe_addr,
  input wire logic [7:0] program_strobe_data,
  input wire logic [7:0] code_byte,
  input wire logic external_access_pin,
  input wire logic reset_event,
  input wire logic fetch_from_external,
  input wire logic code_table_read_instruction,
  output logic code_write_en,
  output logic [7:0] verify_data,
  output logic verify_enable,
  output logic [2:0] lock_bits_byte,
  output logic table_read_allowed,
  output logic external_access_latched,
  output logic external_exec_allowed,
  output logic data_ram_allowed,
  output logic programming_allowed
);
  logic [2:0] locks;
  logic [7:0] key [KEY_DEPTH];
  logic key_programmed;
  logic item_done;
  logic item_done_q;
  logic [2:0] mode_q;
  logic item_start;
  logic ea_latch;
  logic commit;

  function automatic logic [7:0] scramble(input logic [7:0] c,
                                          input logic [7:0] k);
    scramble = ~(c ^ k);
  endfunction

  // level decode shared by the gate outputs and the verify path
  function automatic logic level_two(input logic [2:0] l);
    level_two = l[0] && l[1];
  endfunction

  function automatic logic level_three(input logic [2:0] l);
    level_three = l[0] && l[1] && l[2];
  endfunction

  // ****************************************************************
  // pulse counting
  // ****************************************************************
  assign item_start = (program_strobe_mode[2:0] != mode_q);

  strobe_counter u_strobe (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .program_strobe_n(program_strobe_n),
    .supply_raised(supply_raised),
    .item_start(item_start),
    .item_done(item_done)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_IDLE;
      item_done_q <= 1'b0;
    end else begin
      mode_q <= program_strobe_mode;
      item_done_q <= item_done;
    end
  end

  // one commit per item: rising edge of the done level
  assign commit = item_done && !item_done_q;

  // ****************************************************************
  // lock bits
  // ****************************************************************
  // the erase reset stands in for nonvolatile storage; rst_n is only the
  // power-up value of the model, real cells keep their state [R16]
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      locks <= LOCKS_ERASED;
    end else if (erase_all) begin
      locks <= LOCKS_ERASED; // [R16]
    end else if (commit) begin
      // further lock bits stay programmable after the first
      if (program_strobe_mode == MODE_LOCK1) locks[0] <= 1'b1;
      else if (program_strobe_mode == MODE_LOCK2) locks[1] <= 1'b1;
      else if (program_strobe_mode == MODE_LOCK3) locks[2] <= 1'b1;
    end
  end

  assign lock_bits_byte = locks;

  // ****************************************************************
  // key array
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < KEY_DEPTH; i++) key[i] <= ERASED_BYTE; // [R10]
    end else if (erase_all) begin
      for (int i = 0; i < KEY_DEPTH; i++) key[i] <= ERASED_BYTE; // [R10]
    end else if (commit && program_strobe_mode == MODE_KEY && !locks[0]) begin
      key[program_strobe_addr[KEY_AW-1:0]] <= program_strobe_data;
    end
  end

  always_comb begin
    key_programmed = 1'b0;
    for (int i = 0; i < KEY_DEPTH; i++) begin
      if (key[i] != ERASED_BYTE) key_programmed = 1'b1;
    end
  end

  // ****************************************************************
  // protection levels
  // ****************************************************************
  assign programming_allowed = !locks[0]; // [R2]
  assign code_write_en = commit && program_strobe_mode == MODE_CODE && !locks[0];
  assign table_read_allowed =
    !(locks[0] && fetch_from_external && code_table_read_instruction);
  // [R2] [R12]
  assign external_exec_allowed = !level_three(locks); // [R4]
  assign data_ram_allowed = !level_three(locks); // [R4]

  // access pin caught on every reset_event cycle, used once lock one is set; an unlocked
  // part follows the pin live [R2] [R12]
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ea_latch <= 1'b0;
    end else if (reset_event) begin
      ea_latch <= external_access_pin;
    end
  end
  assign external_access_latched = locks[0] ? ea_latch : external_access_pin;

  // ****************************************************************
  // verify path
  // ****************************************************************
  // verify is refused from level two on, keyed or not [R3] [R13]
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      verify_enable <= 1'b0;
    end else begin
      verify_enable <= (program_strobe_mode == MODE_VERIFY) &&
                       !level_two(locks); // [R3] [R13]
    end
  end

  // an erased key is all ones, so xnor passes the byte through [R1] [R15]
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      verify_data <= 8'h00;
    end else if (program_strobe_mode == MODE_VERIFY && !level_two(locks)) begin
      verify_data <= key_programmed ?
        scramble(code_byte, key[program_strobe_addr[KEY_AW-1:0]]) :
        code_byte; // [R15] [R1]
    end else begin
      verify_data <= 8'h00; // [R3] [R13]
    end
  end
endmodule // code_memory_security_lock

// *** dv/program_strobe_model.sv ***
/* programmer model: mode, supply, strobe, address and data pins;
   assumes core_clk at 40 MHz and a bench that picks the items */
`timescale 1ns/1ps
module program_strobe_model
  import lock_pkg::*;
(
  input wire logic core_clk,
  output logic [2:0] program_strobe_mode = 3'h0,
  output logic supply_raised = 1'b0,
  output logic program_strobe_n = 1'b1,
  output logic [CODE_AW-1:0] program_strobe_addr = 12'h000,
  output logic [7:0] program_strobe_data = 8'h00
);
  // ****************************************
  // pin tasks
  // ****************************************
  task automatic drive(input logic [2:0] m, input logic [11:0] a);
    program_strobe_mode <= m;
    program_strobe_addr <= a;
  endtask
  // only the four defined lock patterns are ever sent
  task automatic item(input logic [2:0] m, input logic [11:0] a,
                      input logic [7:0] d);
    @(posedge core_clk);
    drive(m, a);
    program_strobe_data <= d;
    supply_raised <= 1'b1;
    repeat (400) @(posedge core_clk);
    repeat (PULSES_PER_ITEM) begin
      program_strobe_n <= 1'b0;
      repeat (3620) @(posedge core_clk);
      program_strobe_n <= 1'b1;
      repeat (400) @(posedge core_clk);
    end
    supply_raised <= 1'b0;
    drive(3'h0, ~a);
    program_strobe_data <= ~d; // released bus must not keep the last byte
  endtask
endmodule // program_strobe_model

// *** dv/lock_asserts.sv ***
/* checker on the lock block ports; assumes one clock and rst_n */
`timescale 1ns/1ps
module lock_asserts
  import lock_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic erase_all,
  input wire logic [2:0] program_strobe_mode,
  input wire logic fetch_from_external,
  input wire logic code_table_read_instruction,
  input wire logic reset_event,
  input wire logic code_write_en,
  input wire logic [7:0] verify_data,
  input wire logic verify_enable,
  input wire logic [2:0] lock_bits_byte,
  input wire logic table_read_allowed,
  input wire logic external_access_latched,
  input wire logic external_exec_allowed,
  input wire logic data_ram_allowed,
  input wire logic programming_allowed
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  tbl_block_a: assert property (
    lock_bits_byte[0] && fetch_from_external && code_table_read_instruction
    |-> !table_read_allowed) else $error("table read open");
  program_strobe_stop_a: assert property (
    lock_bits_byte[0] |-> !programming_allowed && !code_write_en)
    else $error("programming open");
  pin_hold_a: assert property (
    lock_bits_byte[0] && !reset_event && !erase_all
    |=> $stable(external_access_latched))
    else $error("latched pin moved");
  verify_off_a: assert property (
    lock_bits_byte[1:0] == 2'b11 |=> !verify_enable && verify_data == 8'h00)
    else $error("verify open");
  verify_on_a: assert property (
    lock_bits_byte[1:0] != 2'b11 && program_strobe_mode == MODE_VERIFY
    |=> verify_enable) else $error("verify missing");
  exec_block_a: assert property (
    lock_bits_byte[2] |-> !external_exec_allowed && !data_ram_allowed)
    else $error("exec open");
  open_a: assert property (
    lock_bits_byte == 3'h0 |-> table_read_allowed && programming_allowed
    && external_exec_allowed && data_ram_allowed) else $error("locked");
  lock_keep_a: assert property (
    !erase_all |=> (lock_bits_byte & $past(lock_bits_byte))
    == $past(lock_bits_byte)) else $error("lock lost");
  erase_a: assert property (
    erase_all [*2] |-> lock_bits_byte == 3'h0) else $error("no erase");
  cover property (lock_bits_byte == 3'h7);
  cover property (verify_enable);
  cover property (lock_bits_byte[0] && reset_event);
  cover property (code_write_en);
endmodule // lock_asserts
bind code_memory_security_lock lock_asserts chk (.*);

// *** dv/code_memory_security_lock_tb.sv ***
/* bench for the lock block; verify bytes are scored from a queue;
   assumes the programmer model drives the programming pins */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module code_memory_security_lock_tb
  import lock_pkg::*;
;
  logic core_clk = 0, rst_n = 0, erase_all = 0, reset_event = 0;
  logic external_access_pin = 0, fetch_from_external = 1;
  logic code_table_read_instruction = 1;
  logic [7:0] code_byte = 8'h00, program_strobe_data, verify_data, e;
  logic [2:0] program_strobe_mode, lock_bits_byte;
  logic supply_raised, program_strobe_n, code_write_en, verify_enable;
  logic [CODE_AW-1:0] program_strobe_addr;
  logic table_read_allowed, external_access_latched, external_exec_allowed;
  logic data_ram_allowed, programming_allowed;
  logic [7:0] key [KEY_DEPTH];
  logic [7:0] q [$];
  logic [31:0] seed = 32'd72787, r;
  int fail_count = 0, checked = 0, writes = 0;
  code_memory_security_lock uut (.*);
  program_strobe_model prg (.*);
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (code_write_en === 1'b1) writes++;
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic give_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic settle();
    @(posedge core_clk);
    #1;
  endtask
  // half the reads hit key byte 5 so the keyed byte is really used
  task automatic vchk(input int n, input bit on);
    logic [5:0] a;
    repeat (n) begin
      r = rnd();
      a = r[0] ? 6'd5 : r[5:0];
      @(posedge core_clk);
      prg.drive(MODE_VERIFY, {r[11:6], a});
      code_byte <= r[23:16];
      if (on) q.push_back(r[23:16] ~^ key[a]);
    end
    @(posedge core_clk);
    prg.drive(MODE_IDLE, 12'h000);
    repeat (3) @(posedge core_clk);
  endtask
  always @(posedge core_clk) if (verify_enable === 1'b1) begin
    if (q.size() == 0) `CHK(1'b1, 1'b0)
    else begin
      e = q.pop_front();
      `CHK(verify_data, e)
    end
  end
  initial begin
    repeat (106000) @(posedge core_clk);
    fail_count++;
    give_verdict();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    foreach (key[i]) key[i] = ERASED_BYTE;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    settle();
    `CHK(lock_bits_byte, LOCKS_ERASED)
    `CHK(table_read_allowed, 1'b1)
    `CHK(external_access_latched, 1'b0)
    vchk(6, 1);
    r = rnd();
    key[5] = r[7:0];
    prg.item(MODE_KEY, 12'h005, key[5]);
    vchk(12, 1);
    prg.item(MODE_CODE, {6'h00, r[13:8]}, r[15:8]);
    settle();
    `CHK(writes, 1)
    for (int i = 0; i < 3; i++) begin
      prg.item(3'(3 + i), 12'h000, 8'h00);
      settle();
      `CHK(lock_bits_byte, 3'((2 << i) - 1))
      `CHK(table_read_allowed, 1'b0)
      `CHK(programming_allowed, 1'b0)
      `CHK(external_exec_allowed, i != 2)
      `CHK(data_ram_allowed, i != 2)
      vchk(4, i == 0);
    end
    @(posedge core_clk);
    external_access_pin <= 1'b1;
    reset_event <= 1'b1;
    fetch_from_external <= 1'b0;
    @(posedge core_clk);
    reset_event <= 1'b0;
    external_access_pin <= 1'b0;
    settle();
    `CHK(external_access_latched, 1'b1)
    `CHK(table_read_allowed, 1'b1)
    `CHK(writes, 1)
    `CHK(lock_bits_byte, 3'h7)
    @(posedge core_clk);
    erase_all <= 1'b1;
    repeat (2) @(posedge core_clk);
    erase_all <= 1'b0;
    settle();
    `CHK(lock_bits_byte, LOCKS_ERASED)
    foreach (key[i]) key[i] = ERASED_BYTE;
    vchk(6, 1);
    give_verdict();
  end
endmodule // code_memory_security_lock_tb
